// ==== rtl/amc_regs_map.svh ====
`ifndef AMC_REGS_MAP_SVH
`define AMC_REGS_MAP_SVH
// Register byte addresses; the printed offsets 0x1A..0x1C are not word multiples,
// so they are kept as indices and the byte address is four times the index.
`define AMC_IDX_SSP 8'h1A
`define AMC_IDX_OSC 8'h1B
`define AMC_IDX_BER 8'h1C
`define AMC_IDX_MUX 8'h20
`define AMC_IDX_STAT 8'h30
`define AMC_ADDR_SSP 12'h068
`define AMC_ADDR_OSC 12'h06C
`define AMC_ADDR_BER 12'h070
`define AMC_ADDR_MUX 12'h080
`define AMC_ADDR_STAT 12'h0C0
// Reset values.
`define AMC_RST_SSP 8'h0F
`define AMC_RST_OSC 8'h82
`define AMC_RST_BER 8'h02
`define AMC_RST_MUX 32'h0001_7772
// Field positions.
`define AMC_SSP_DIS_BIT 7
`define AMC_OSC_DONE_BIT 6
`define AMC_OSC_FDIS_BIT 1
`define AMC_MUX_C1MOD_BIT 23
`define AMC_MUX_C2MOD_BIT 19
// Timing: one millisecond tick at 20 MHz, and the trim run length in ticks.
`define AMC_CLK_HZ 20000000
`define AMC_TICK_CYC 20000
`define AMC_TRIM_MS 2
// Source codes.
`define AMC_SRC_LEFT 3'h0
`define AMC_SRC_RIGHT 3'h1
`define AMC_SRC_ZERO 3'h6
`endif

// ==== rtl/amc_pkg.sv ====
package amc_pkg;
    // Channel routing and scheme as seen by the modulator.
    typedef struct packed {
        logic threeLevel;
        logic [1:0] source;
    } amc_chan_s;
    // Soft-step and recovery sequencer states.
    typedef enum logic [1:0] {
        AMC_RUN = 2'b00,
        AMC_SOFT = 2'b01,
        AMC_FAULT = 2'b10
    } amc_seq_e;
endpackage

// ==== rtl/amc_ms_timer.sv ====
`timescale 1ns/1ps
`include "amc_regs_map.svh"
// Millisecond down counter driven by a one-cycle tick enable.
module amc_ms_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [13:0] loadMs,
    output logic busy
);
    logic [14:0] tickCnt_q;
    logic [13:0] msLeft_q;
    wire tick = (tickCnt_q == 15'(`AMC_TICK_CYC - 1));
    // Prescaler gives one tick per millisecond.
    always_ff @(posedge clk) begin
        if (reset || load || tick) begin
            tickCnt_q <= 15'h0000;
        end else begin
            tickCnt_q <= tickCnt_q + 15'h0001;
        end
    end
    // Count remaining milliseconds down to zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            msLeft_q <= 14'h0000;
        end else if (load) begin
            msLeft_q <= loadMs;
        end else if (tick && msLeft_q != 14'h0000) begin
            msLeft_q <= msLeft_q - 14'h0001;
        end
    end
    assign busy = (msLeft_q != 14'h0000);
endmodule

// ==== rtl/amc_modulator_regs.sv ====
`timescale 1ns/1ps
`include "amc_regs_map.svh"
// Functional notes
// - Soft period on shutdown commands and power-down changes.
// - Bit 7 set disables soft-step timer.
// - Bits 4:0 choose period, 00 none.
// - Period field resets to code 01111.
// - Internal oscillator detects audio clock rates.
// - Writing 0x00 applies factory trim.
// - Bit 6 reads trim done, clear at reset.
// - Bit 1 resets high, zero selects factory.
// - Fault resets stage, stops PWM, waits, restarts.
// - Bits 3:0 select recovery wait 299..1496 ms.
// - Recovery register written once, non-reserved only.
// - Bits 23/19 pick two or three level.
// - Channel 1 source: left, right, zero.
// - Channel 2 source: left, right, zero.
module amc_modulator_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_down_input,
    input wire logic shutdownCmd,
    input wire logic backEndFault,
    input wire logic serialClkActive,
    output logic pwmEnable,
    output logic softStepActive,
    output logic stageReset,
    output logic trimApplied,
    output logic factoryTrimSel,
    output amc_pkg::amc_chan_s chan1Cfg,
    output amc_pkg::amc_chan_s chan2Cfg,
    output logic [2:0] chan1Src,
    output logic [2:0] chan2Src
);
    ////////////////////////////////////////////////////////////////////////////
    // Millisecond lookups for the period codes.
    function automatic logic [13:0] softMs(input logic [4:0] code);
        case (code)
            5'h08: softMs = 14'd17;
            5'h09: softMs = 14'd24;
            5'h0A: softMs = 14'd31;
            5'h0B: softMs = 14'd40;
            5'h0C: softMs = 14'd54;
            5'h0D: softMs = 14'd70;
            5'h0E: softMs = 14'd94;
            5'h0F: softMs = 14'd126;
            5'h10: softMs = 14'd165;
            5'h11: softMs = 14'd239;
            5'h12: softMs = 14'd314;
            5'h13: softMs = 14'd404;
            5'h14: softMs = 14'd539;
            5'h15: softMs = 14'd703;
            5'h16: softMs = 14'd943;
            5'h17: softMs = 14'd1257;
            5'h18: softMs = 14'd1728;
            5'h19: softMs = 14'd2514;
            5'h1A: softMs = 14'd3299;
            5'h1B: softMs = 14'd4242;
            5'h1C: softMs = 14'd5656;
            5'h1D: softMs = 14'd7384;
            5'h1E: softMs = 14'd9897;
            5'h1F: softMs = 14'd13196;
            default: softMs = 14'd0; // Codes with bits 4:3 at 00 mean no period.
        endcase
    endfunction

    // Recovery wait for a back-end fault; 101x and 11xx saturate.
    function automatic logic [13:0] recoveryMs(input logic [3:0] code);
        case (code)
            4'h2: recoveryMs = 14'd299;
            4'h3: recoveryMs = 14'd449;
            4'h4: recoveryMs = 14'd598;
            4'h5: recoveryMs = 14'd748;
            4'h6: recoveryMs = 14'd898;
            4'h7: recoveryMs = 14'd1047;
            4'h8: recoveryMs = 14'd1197;
            4'h9: recoveryMs = 14'd1346;
            default: recoveryMs = 14'd1496;
        endcase
    endfunction

    // Only documented source codes are accepted.
    function automatic logic srcValid(input logic [2:0] code);
        srcValid = (code == `AMC_SRC_LEFT) || (code == `AMC_SRC_RIGHT) ||
            (code == `AMC_SRC_ZERO);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0] ssp_q;          // Start/stop period control.
    logic oscFactDis_q;         // Factory trim disabled flag.
    logic trimDone_q;           // Trim completed status.
    logic trimRun_q;            // Trim in progress.
    logic [3:0] ber_q;          // Recovery period code.
    logic berLocked_q;          // Set after the single allowed write.
    logic [7:0] muxHi_q;        // Bits 23:16 of the multiplexer register.
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [1:0] pdnSync_q;      // Power-down pin synchroniser.
    logic [1:0] sdSync_q;       // Shutdown command synchroniser.
    logic [1:0] faultSync_q;    // Fault synchroniser.
    logic [1:0] sclkSync_q;     // Audio clock detect synchroniser.
    logic pdnLast_q;
    logic sdLast_q;
    logic faultLast_q;
    amc_pkg::amc_seq_e seq_q;
    amc_pkg::amc_seq_e seq_d;
    logic pwmEnable_q;
    logic softStep_q;
    logic stageReset_q;
    logic trimApplied_q;
    // Reset words as named wires, so single fields can be picked out of them.
    wire [7:0] rstOsc = `AMC_RST_OSC;
    wire [7:0] rstBer = `AMC_RST_BER;
    wire [31:0] rstMux = `AMC_RST_MUX;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. The slave answers in the access phase after one wait state.
    wire access = psel && penable;
    wire hitSsp = (paddr == `AMC_ADDR_SSP);
    wire hitOsc = (paddr == `AMC_ADDR_OSC);
    wire hitBer = (paddr == `AMC_ADDR_BER);
    wire hitMux = (paddr == `AMC_ADDR_MUX);
    wire hitStat = (paddr == `AMC_ADDR_STAT);
    wire mapped = hitSsp || hitOsc || hitBer || hitMux || hitStat;
    wire wr = access && pwrite && !pready_q;
    wire rd = access && !pwrite && !pready_q;
    wire [2:0] wrSrc1 = pwdata[22:20];
    wire [2:0] wrSrc2 = pwdata[18:16];
    // Reserved recovery codes 000x are refused, as is any write after the first accepted one.
    wire berCodeOk = (pwdata[3:1] != 3'h0) && (pwdata[7:4] == 4'h0);
    wire berWrite = wr && hitBer && !berLocked_q && berCodeOk;
    wire muxWrite = wr && hitMux && srcValid(wrSrc1) && srcValid(wrSrc2);
    wire errWrite = wr && ((hitBer && !(berWrite)) || (hitMux && !muxWrite) || hitStat);
    wire [31:0] statWord = {26'h0, trimRun_q, stageReset_q, softStep_q, pwmEnable_q,
        seq_q};
    wire [31:0] rdWord = hitSsp ? {24'h0, ssp_q} :
        hitOsc ? {24'h0, 1'b1, trimDone_q, 4'h0, oscFactDis_q, 1'b0} :
        hitBer ? {28'h0, ber_q} :
        hitMux ? {8'h00, muxHi_q, 16'h7772} :
        hitStat ? statWord : 32'h0000_0000;

    // Bus handshake: ready for one cycle in each access phase.
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access && !pready_q;
            pslverr_q <= (access && !pready_q) && (!mapped || errWrite);
            prdata_q <= rd ? rdWord : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible configuration registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            ssp_q <= `AMC_RST_SSP; // Timer enabled, code 01111.
            ber_q <= rstBer[3:0];
            berLocked_q <= 1'b0;
            muxHi_q <= rstMux[23:16]; // Two-level, left and right.
        end else begin
            if (wr && hitSsp) begin
                ssp_q <= {pwdata[7], 2'b00, pwdata[4:0]};
            end
            if (berWrite) begin
                ber_q <= pwdata[3:0];
                berLocked_q <= 1'b1; // Later writes are ignored.
            end
            if (muxWrite) begin
                muxHi_q <= pwdata[23:16];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator trim. A write starts a trim run; done sets when it ends and
    // stays set. The run needs the audio clock seen by the internal oscillator.
    wire trimWrite = wr && hitOsc;
    logic trimBusy;
    amc_ms_timer trimTimer (
        .clk(clk),
        .reset(reset),
        .load(trimWrite),
        .loadMs(14'(`AMC_TRIM_MS)),
        .busy(trimBusy)
    );
    always_ff @(posedge clk) begin
        if (reset) begin
            oscFactDis_q <= rstOsc[`AMC_OSC_FDIS_BIT];
            trimDone_q <= 1'b0;
            trimRun_q <= 1'b0;
        end else if (trimWrite) begin
            oscFactDis_q <= pwdata[`AMC_OSC_FDIS_BIT]; // 0x00 picks factory trim.
            trimRun_q <= 1'b1;
        end else if (trimRun_q && !trimBusy && sclkSync_q[1]) begin
            trimRun_q <= 1'b0;
            trimDone_q <= 1'b1; // Rate detect locks on the audio clock.
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge clk) begin
        if (reset) begin
            pdnSync_q <= 2'b00;
            sdSync_q <= 2'b00;
            faultSync_q <= 2'b00;
            sclkSync_q <= 2'b00;
            pdnLast_q <= 1'b0;
            sdLast_q <= 1'b0;
            faultLast_q <= 1'b0;
        end else begin
            pdnSync_q <= {pdnSync_q[0], power_down_input};
            sdSync_q <= {sdSync_q[0], shutdownCmd};
            faultSync_q <= {faultSync_q[0], backEndFault};
            sclkSync_q <= {sclkSync_q[0], serialClkActive};
            pdnLast_q <= pdnSync_q[1];
            sdLast_q <= sdSync_q[1];
            faultLast_q <= faultSync_q[1];
        end
    end

    // A change of power-down or of shutdown state outside a fault starts a soft step when bit 7 is clear and the period code is not none.
    wire softEvent = (pdnSync_q[1] != pdnLast_q) || (sdSync_q[1] != sdLast_q);
    wire faultRise = faultSync_q[1] && !faultLast_q;
    wire [13:0] softLen = softMs(ssp_q[4:0]);
    wire softUse = !ssp_q[`AMC_SSP_DIS_BIT] && (softLen != 14'd0);
    wire halted = pdnSync_q[1] || sdSync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer shares one millisecond timer between soft step and recovery.
    logic seqBusy;
    wire seqLoad = faultRise || (seq_q != amc_pkg::AMC_FAULT && softEvent && softUse);
    wire [13:0] seqLen = faultRise ? recoveryMs(ber_q) : softLen;
    amc_ms_timer seqTimer (
        .clk(clk),
        .reset(reset),
        .load(seqLoad),
        .loadMs(seqLen),
        .busy(seqBusy)
    );

    // Next state: a fault wins over a soft step.
    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            amc_pkg::AMC_RUN: begin
                if (faultRise) begin
                    seq_d = amc_pkg::AMC_FAULT;
                end else if (softEvent && softUse) begin
                    seq_d = amc_pkg::AMC_SOFT;
                end
            end
            amc_pkg::AMC_SOFT: begin
                if (faultRise) begin
                    seq_d = amc_pkg::AMC_FAULT;
                end else if (!seqBusy && !seqLoad) begin
                    seq_d = amc_pkg::AMC_RUN;
                end
            end
            amc_pkg::AMC_FAULT: begin
                if (!seqBusy && !seqLoad) begin
                    seq_d = amc_pkg::AMC_RUN; // Retry after the recovery wait.
                end
            end
            default: seq_d = amc_pkg::AMC_RUN;
        endcase
    end

    // Registered outputs to the modulator and power stage.
    always_ff @(posedge clk) begin
        if (reset) begin
            seq_q <= amc_pkg::AMC_RUN;
            pwmEnable_q <= 1'b0;
            softStep_q <= 1'b0;
            stageReset_q <= 1'b0;
            trimApplied_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            pwmEnable_q <= (seq_d == amc_pkg::AMC_RUN) && !halted;
            softStep_q <= (seq_d == amc_pkg::AMC_SOFT);
            stageReset_q <= (seq_d == amc_pkg::AMC_FAULT);
            trimApplied_q <= trimDone_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output drive; channel fields come straight from register bits.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pwmEnable = pwmEnable_q;
    assign softStepActive = softStep_q;
    assign stageReset = stageReset_q;
    assign trimApplied = trimApplied_q;
    assign factoryTrimSel = !oscFactDis_q;
    assign chan1Cfg = '{threeLevel: muxHi_q[7], source: muxHi_q[5:4]};
    assign chan2Cfg = '{threeLevel: muxHi_q[3], source: muxHi_q[1:0]};
    assign chan1Src = muxHi_q[6:4];
    assign chan2Src = muxHi_q[2:0];
endmodule

// ==== verification/amc_regs_sva.sv ====
`timescale 1ns/1ps
`include "amc_regs_map.svh"
// Port-level checks on the register block, bound to every instance.
module amc_regs_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic backEndFault,
    input wire logic pwmEnable,
    input wire logic stageReset,
    input wire logic trimApplied,
    input wire logic factoryTrimSel,
    input wire amc_pkg::amc_chan_s chan1Cfg,
    input wire amc_pkg::amc_chan_s chan2Cfg,
    input wire logic [2:0] chan1Src,
    input wire logic [2:0] chan2Src
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // A write completes at the edge where pready meets the request.
    wire wDone = psel && penable && pready && pwrite;
    wire wOsc = wDone && paddr == `AMC_ADDR_OSC;
    wire wMux = wDone && paddr == `AMC_ADDR_MUX;
    // Only left, right and zero are legal source codes.
    wire badSrc = !(pwdata[22:20] inside {3'h0, 3'h1, 3'h6})
        || !(pwdata[18:16] inside {3'h0, 3'h1, 3'h6});
    ////////////////////////////////////////////////////////////////
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_factory; wOsc |=> factoryTrimSel == !$past(pwdata[1]); endproperty
    a_factory: assert property (p_factory) else $error("trim select");
    property p_doneRst; $fell(reset) |-> !trimApplied; endproperty
    a_doneRst: assert property (p_doneRst) else $error("done after reset");
    property p_doneHold; !$past(reset) && $past(trimApplied) |-> trimApplied; endproperty
    a_doneHold: assert property (p_doneHold) else $error("done dropped");
    property p_mode;
        wMux && !pslverr |=> chan1Cfg.threeLevel == $past(pwdata[23])
            && chan2Cfg.threeLevel == $past(pwdata[19]);
    endproperty
    a_mode: assert property (p_mode) else $error("scheme");
    property p_src;
        wMux && !pslverr |=> chan1Src == $past(pwdata[22:20])
            && chan2Src == $past(pwdata[18:16]);
    endproperty
    a_src: assert property (p_src) else $error("source");
    property p_resv; wMux && badSrc |-> pslverr; endproperty
    a_resv: assert property (p_resv) else $error("reserved taken");
    property p_halt; stageReset |-> !pwmEnable; endproperty
    a_halt: assert property (p_halt) else $error("pwm in fault");
    property p_fault; $rose(backEndFault) |-> ##[1:6] stageReset; endproperty
    a_fault: assert property (p_fault) else $error("no stage reset");
    c_mux: cover property (wMux && !pslverr);
    c_trim: cover property ($rose(trimApplied));
    c_fault: cover property ($rose(stageReset));
endmodule
bind amc_modulator_regs amc_regs_sva u_sva (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .backEndFault(backEndFault), .pwmEnable(pwmEnable),
    .stageReset(stageReset), .trimApplied(trimApplied),
    .factoryTrimSel(factoryTrimSel), .chan1Cfg(chan1Cfg),
    .chan2Cfg(chan2Cfg), .chan1Src(chan1Src), .chan2Src(chan2Src));

// ==== verification/amc_host_model.sv ====
`timescale 1ns/1ps
// Host side of the register port: an APB requester.
module amc_host_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'hFFF;
        pwdata = 32'h0;
    end
    // One transfer, held until pready; a hung slave returns unknowns.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        r = pready ? prdata : 'x;
        e = pready ? pslverr : 1'bx;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so stale values cannot pass for live ones.
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "amc_regs_map.svh"
module testbench;
    logic clk, reset, pwrDown, shutCmd, fault, sclkOk;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pwmEn, softStep, stageRst, trimDone, facSel;
    logic [2:0] c1Src, c2Src;
    amc_pkg::amc_chan_s c1Cfg, c2Cfg;
    int errCount = 0;
    int nChecks = 0;
    logic [2:0] codes [3] = '{3'h0, 3'h1, 3'h6};
    amc_host_model host (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    amc_modulator_regs dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_down_input(pwrDown), .shutdownCmd(shutCmd),
        .backEndFault(fault), .serialClkActive(sclkOk), .pwmEnable(pwmEn),
        .softStepActive(softStep), .stageReset(stageRst),
        .trimApplied(trimDone), .factoryTrimSel(facSel), .chan1Cfg(c1Cfg),
        .chan2Cfg(c2Cfg), .chan1Src(c1Src), .chan2Src(c2Src));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Write and check whether the block refused it.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic g;
        host.xfer(1'b1, a, d, r, g);
        chk(32'(g), 32'(e));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic g;
        host.xfer(1'b0, a, 32'h0, r, g);
        chk(r, x);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic tReset;
        rd(`AMC_ADDR_SSP, 32'h0000_000F);
        rd(`AMC_ADDR_OSC, 32'h0000_0082);
        rd(`AMC_ADDR_MUX, 32'h0001_7772);
        chk(32'(c1Src), 32'h0);
        chk(32'(c2Src), 32'h1);
        chk(32'(facSel), 32'h0);
        wr(12'h100, 32'h0, 1'b1);
    endtask
    // Every legal source code on both channels, then reserved codes.
    task automatic tMux;
        logic [31:0] v;
        for (int i = 0; i < 3; i++) begin
            v = {8'h00, i[0], codes[i], !i[0], codes[(i + 1) % 3], 16'h7772};
            wr(`AMC_ADDR_MUX, v, 1'b0);
            chk(32'(c1Src), 32'(codes[i]));
            chk(32'(c2Src), 32'(codes[(i + 1) % 3]));
            chk(32'(c1Cfg.threeLevel), 32'(i[0]));
            chk(32'(c2Cfg.threeLevel), 32'(!i[0]));
            rd(`AMC_ADDR_MUX, v);
        end
        wr(`AMC_ADDR_MUX, {v[31:23], 3'h2, v[19:0]}, 1'b1);
        wr(`AMC_ADDR_MUX, {v[31:19], 3'h7, v[15:0]}, 1'b1);
        rd(`AMC_ADDR_MUX, v);
    endtask
    // Trim is started by the host after the reset and multiplexer tests.
    task automatic tTrim;
        int n;
        n = 0;
        wr(`AMC_ADDR_OSC, 32'h0, 1'b0);
        chk(32'(facSel), 32'h1);
        while (trimDone !== 1'b1 && n < 60000) begin
            cyc(1);
            n++;
        end
        chk(32'(trimDone), 32'h1);
        rd(`AMC_ADDR_OSC, 32'h0000_00C0);
    endtask
    task automatic tSoft;
        wr(`AMC_ADDR_SSP, 32'h0000_008F, 1'b0);
        rd(`AMC_ADDR_SSP, 32'h0000_008F);
        shutCmd <= 1'b1;
        cyc(8);
        chk(32'(softStep), 32'h0);
        wr(`AMC_ADDR_SSP, 32'h0000_000F, 1'b0);
        pwrDown <= 1'b1;
        cyc(8);
        chk(32'(softStep), 32'h1);
    endtask
    // The recovery period is taken once; the fault halts the stage.
    task automatic tFault;
        wr(`AMC_ADDR_BER, 32'h1, 1'b1);
        wr(`AMC_ADDR_BER, 32'h3, 1'b0);
        wr(`AMC_ADDR_BER, 32'h9, 1'b1);
        rd(`AMC_ADDR_BER, 32'h3);
        fault <= 1'b1;
        cyc(8);
        chk(32'(stageRst), 32'h1);
        chk(32'(pwmEn), 32'h0);
    endtask
    task automatic tReset2;
        fault <= 1'b0;
        cyc(2);
        reset <= 1'b1;
        cyc(12);
        reset <= 1'b0;
        cyc(1);
        chk(32'(trimDone), 32'h0);
        rd(`AMC_ADDR_OSC, 32'h0000_0082);
        wr(`AMC_ADDR_BER, 32'h4, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic wrapUp;
        if (errCount == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog well above the trim wait plus all transfers.
    initial begin
        cyc(90000);
        errCount++;
        wrapUp();
    end
    initial begin
        reset = 1'b1;
        pwrDown = 1'b0;
        shutCmd = 1'b0;
        fault = 1'b0;
        sclkOk = 1'b1;
        cyc(12);
        reset <= 1'b0;
        cyc(1);
        tReset();
        tMux();
        tTrim();
        tSoft();
        tFault();
        tReset2();
        wrapUp();
    end
endmodule
